// File: design/mst_pkg.sv
package mst_pkg;

    // Link-side counts, all in cycles of the relevant bit clock.
    localparam int unsigned PREAMBLE_BITS     = 64;
    localparam int unsigned JAM_BITS          = 32;
    localparam int unsigned HEARTBEAT_WINDOW  = 64;
    localparam int unsigned CRS_END_CYCLES    = 2;
    localparam int unsigned DRIBBLE_LIMIT     = 5;
    localparam int unsigned RX_RECOVERY_MAX   = 40;

    // Reset values.
    localparam logic [7:0] BYTE_RESET         = 8'h00;

    typedef enum logic [2:0] {
        TX_IDLE,
        TX_PREAMBLE,
        TX_DATA,
        TX_JAM,
        TX_HEARTBEAT,
        TX_DRAIN
    } mst_tx_state_t;

    typedef enum logic [1:0] {
        RX_IDLE,
        RX_HUNT,
        RX_DATA,
        RX_END
    } mst_rx_state_t;

    typedef struct packed {
        logic       last;
        logic [7:0] data;
    } mst_tx_byte_t;

    typedef struct packed {
        logic packet_transmitted;
        logic collided;
        logic underrun;
        logic heartbeat_missing_flag;
    } mst_tx_status_t;

    localparam mst_tx_status_t TX_STATUS_RESET = '{default: 1'b0};

    typedef struct packed {
        logic       align_error;
        logic [7:0] data;
    } mst_rx_info_t;

endpackage : mst_pkg

// File: design/mst_sync.sv
module mst_sync #(
    parameter int unsigned W = 1
) (
    // Destination clock and reset.
    input  wire logic         i_clk,
    input  wire logic         i_resetn,
    // Asynchronous input and its synchronised copy.
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);

    logic [W-1:0] meta_reg;

    // The first stage feeds only the second stage.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            meta_reg <= '0;
            o_q      <= '0;
        end else begin
            meta_reg <= i_d;
            o_q      <= meta_reg;
        end
    end

endmodule : mst_sync

// File: design/mst_serial_side.sv
// What this block does
// - Line enable and first preamble bit one together
// - After a frame sent without collision or underrun, no collision in 64 clocks sets heartbeat missing
// - Jam starts after byte finishes, collision synchronised
// - Exactly 32 jam bits, all ones
// - First two consecutive ones mark frame start
// - Up to five dribble bits cause no error
// - End-of-receive processing done within 40 clocks
// - Carrier ends after two low receive clocks
module mst_serial_side (
    // Core clock, enable and reset.
    input  wire logic                  i_core_clk,
    input  wire logic                  i_core_clk_en,
    input  wire logic                  i_resetn,
    // Transmit byte stream from the core side.
    input  wire logic                  i_tx_valid,
    input  wire mst_pkg::mst_tx_byte_t i_tx_byte,
    output logic                       o_tx_ready,
    output logic                       o_tx_done,
    output mst_pkg::mst_tx_status_t    o_transmit_status_reg,
    // Receive byte stream to the core side.
    output mst_pkg::mst_rx_info_t      o_rx_info,
    output logic                       o_rx_byte_valid,
    output logic                       o_rx_frame_end,
    // Transmit link.
    input  wire logic                  i_tx_bit_clock,
    input  wire logic                  i_collision,
    output logic                       o_tx_line_enable,
    output logic                       o_tx_data,
    // Receive link.
    input  wire logic                  i_rx_bit_clock,
    input  wire logic                  i_carrier_sense_in,
    input  wire logic                  i_rx_data
);

    mst_pkg::mst_tx_byte_t hold_reg;
    logic                  req_tgl_reg;
    logic [3:0]            core_sync;
    logic [3:0]            core_sync_d_reg;
    logic                  ack_edge;
    logic                  done_edge;
    logic                  rxb_edge;
    logic                  rxe_edge;

    logic                    ack_tgl_reg;
    logic                    done_tgl_reg;
    logic                    rxb_tgl_reg;
    logic                    rxe_tgl_reg;
    mst_pkg::mst_tx_status_t tx_stat_reg;
    mst_pkg::mst_rx_info_t   rx_info_reg;

    mst_sync #(.W(4)) u_core_sync (
        .i_clk    (i_core_clk),
        .i_resetn (i_resetn),
        .i_d      ({ack_tgl_reg, done_tgl_reg, rxb_tgl_reg, rxe_tgl_reg}),
        .o_q      (core_sync)
    );

    assign ack_edge  = core_sync[3] ^ core_sync_d_reg[3];
    assign done_edge = core_sync[2] ^ core_sync_d_reg[2];
    assign rxb_edge  = core_sync[1] ^ core_sync_d_reg[1];
    assign rxe_edge  = core_sync[0] ^ core_sync_d_reg[0];

    // Edge history freezes with the enable, so no event is lost.
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            core_sync_d_reg <= 4'h0;
        end else if (i_core_clk_en) begin
            core_sync_d_reg <= core_sync;
        end
    end

    // One-byte holding stage; ready stays low until the ack returns.
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            hold_reg    <= '{last: 1'b0, data: mst_pkg::BYTE_RESET};
            req_tgl_reg <= 1'b0;
            o_tx_ready  <= 1'b1;
        end else if (i_core_clk_en) begin
            if (o_tx_ready && i_tx_valid) begin
                hold_reg    <= i_tx_byte;
                req_tgl_reg <= ~req_tgl_reg;
                o_tx_ready  <= 1'b0;
            end else if (ack_edge) begin
                o_tx_ready  <= 1'b1;
            end
        end
    end

    // Status of the last frame; this register holds it stable until the next frame ends.
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_transmit_status_reg <= mst_pkg::TX_STATUS_RESET;
            o_tx_done             <= 1'b0;
        end else if (i_core_clk_en) begin
            o_tx_done <= done_edge;
            if (done_edge) begin
                o_transmit_status_reg <= tx_stat_reg;
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rx_info       <= '{align_error: 1'b0, data: mst_pkg::BYTE_RESET};
            o_rx_byte_valid <= 1'b0;
            o_rx_frame_end  <= 1'b0;
        end else if (i_core_clk_en) begin
            o_rx_byte_valid <= rxb_edge;
            o_rx_frame_end  <= rxe_edge;
            if (rxb_edge || rxe_edge) begin
                o_rx_info <= rx_info_reg;
            end
        end
    end

    mst_pkg::mst_tx_state_t tx_state_reg;
    logic [1:0]             tx_sync;
    logic                   req_d_reg;
    logic                   req_edge;
    logic                   col_s;
    logic                   tx_avail_reg;
    mst_pkg::mst_tx_byte_t  tx_hold_reg;
    logic [7:0]             shift_reg;
    logic                   last_reg;
    logic [5:0]             cnt_reg;
    logic                   col_pend_reg;
    logic                   hb_seen_reg;
    logic                   col_now;

    mst_sync #(.W(2)) u_tx_sync (
        .i_clk    (i_tx_bit_clock),
        .i_resetn (i_resetn),
        .i_d      ({req_tgl_reg, i_collision}),
        .o_q      (tx_sync)
    );

    assign req_edge = tx_sync[1] ^ req_d_reg;
    assign col_s    = tx_sync[0];
    assign col_now  = col_pend_reg | col_s;

    function automatic logic preamble_bit(input logic [5:0] idx);
        preamble_bit = (idx == 6'(mst_pkg::PREAMBLE_BITS - 1)) | ~idx[0];
    endfunction : preamble_bit

    // Request edges arrive only while the core holds its byte stable.
    always_ff @(posedge i_tx_bit_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            req_d_reg <= 1'b0;
        end else begin
            req_d_reg <= tx_sync[1];
        end
    end

    always_ff @(posedge i_tx_bit_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            tx_state_reg     <= mst_pkg::TX_IDLE;
            o_tx_line_enable <= 1'b0;
            o_tx_data        <= 1'b0;
            tx_avail_reg     <= 1'b0;
            tx_hold_reg      <= '{last: 1'b0, data: mst_pkg::BYTE_RESET};
            ack_tgl_reg      <= 1'b0;
            done_tgl_reg     <= 1'b0;
            tx_stat_reg      <= mst_pkg::TX_STATUS_RESET;
            shift_reg        <= mst_pkg::BYTE_RESET;
            last_reg         <= 1'b0;
            cnt_reg          <= 6'h00;
            col_pend_reg     <= 1'b0;
            hb_seen_reg      <= 1'b0;
        end else begin
            if (req_edge) begin
                tx_avail_reg <= 1'b1;
                tx_hold_reg  <= hold_reg;
            end
            case (tx_state_reg)
                mst_pkg::TX_IDLE: begin
                    col_pend_reg <= 1'b0;
                    if (tx_avail_reg) begin
                        o_tx_line_enable <= 1'b1;
                        o_tx_data        <= preamble_bit(6'h00);
                        cnt_reg          <= 6'h00;
                        tx_stat_reg      <= mst_pkg::TX_STATUS_RESET;
                        tx_state_reg     <= mst_pkg::TX_PREAMBLE;
                    end
                end
                mst_pkg::TX_PREAMBLE: begin
                    col_pend_reg <= col_now;
                    if (col_now && cnt_reg[2:0] == 3'h7) begin
                        o_tx_data    <= 1'b1;
                        cnt_reg      <= 6'h00;
                        last_reg     <= 1'b0;
                        tx_state_reg <= mst_pkg::TX_JAM;
                    end else if (cnt_reg == 6'(mst_pkg::PREAMBLE_BITS - 1)) begin
                        if (tx_avail_reg) begin
                            tx_avail_reg <= 1'b0;
                            ack_tgl_reg  <= ~ack_tgl_reg;
                            shift_reg    <= tx_hold_reg.data;
                            last_reg     <= tx_hold_reg.last;
                            o_tx_data    <= tx_hold_reg.data[0];
                            cnt_reg      <= 6'h00;
                            tx_state_reg <= mst_pkg::TX_DATA;
                        end else begin
                            o_tx_line_enable     <= 1'b0;
                            o_tx_data            <= 1'b0;
                            last_reg             <= 1'b0;
                            tx_stat_reg.underrun <= 1'b1;
                            tx_state_reg         <= mst_pkg::TX_DRAIN;
                        end
                    end else begin
                        cnt_reg   <= cnt_reg + 6'h01;
                        o_tx_data <= preamble_bit(cnt_reg + 6'h01);
                    end
                end
                mst_pkg::TX_DATA: begin
                    col_pend_reg <= col_now;
                    if (cnt_reg[2:0] != 3'h7) begin
                        cnt_reg   <= cnt_reg + 6'h01;
                        shift_reg <= shift_reg >> 1;
                        o_tx_data <= shift_reg[1];
                    end else if (col_now) begin
                        o_tx_data    <= 1'b1;
                        cnt_reg      <= 6'h00;
                        tx_state_reg <= mst_pkg::TX_JAM;
                    end else if (last_reg) begin
                        o_tx_line_enable <= 1'b0;
                        o_tx_data        <= 1'b0;
                        cnt_reg          <= 6'h00;
                        hb_seen_reg      <= 1'b0;
                        tx_state_reg     <= mst_pkg::TX_HEARTBEAT;
                    end else if (tx_avail_reg) begin
                        tx_avail_reg <= 1'b0;
                        ack_tgl_reg  <= ~ack_tgl_reg;
                        shift_reg    <= tx_hold_reg.data;
                        last_reg     <= tx_hold_reg.last;
                        o_tx_data    <= tx_hold_reg.data[0];
                        cnt_reg      <= 6'h00;
                    end else begin
                        o_tx_line_enable     <= 1'b0;
                        o_tx_data            <= 1'b0;
                        tx_stat_reg.underrun <= 1'b1;
                        tx_state_reg         <= mst_pkg::TX_DRAIN;
                    end
                end
                mst_pkg::TX_JAM: begin
                    if (cnt_reg == 6'(mst_pkg::JAM_BITS - 1)) begin
                        o_tx_line_enable     <= 1'b0;
                        o_tx_data            <= 1'b0;
                        tx_stat_reg.collided <= 1'b1;
                        tx_state_reg         <= mst_pkg::TX_DRAIN;
                    end else begin
                        cnt_reg   <= cnt_reg + 6'h01;
                        o_tx_data <= 1'b1;
                    end
                end
                mst_pkg::TX_HEARTBEAT: begin
                    hb_seen_reg <= hb_seen_reg | col_s;
                    if (cnt_reg == 6'(mst_pkg::HEARTBEAT_WINDOW - 1)) begin
                        tx_stat_reg.heartbeat_missing_flag <= ~(hb_seen_reg | col_s);
                        tx_stat_reg.packet_transmitted     <= 1'b1;
                        done_tgl_reg                       <= ~done_tgl_reg;
                        tx_state_reg                       <= mst_pkg::TX_IDLE;
                    end else begin
                        cnt_reg <= cnt_reg + 6'h01;
                    end
                end
                mst_pkg::TX_DRAIN: begin
                    // The rest of an aborted frame is dropped up to its last byte.
                    if (last_reg) begin
                        done_tgl_reg <= ~done_tgl_reg;
                        tx_state_reg <= mst_pkg::TX_IDLE;
                    end else if (tx_avail_reg) begin
                        tx_avail_reg <= 1'b0;
                        ack_tgl_reg  <= ~ack_tgl_reg;
                        last_reg     <= tx_hold_reg.last;
                    end
                end
                default: begin
                    tx_state_reg <= mst_pkg::TX_IDLE;
                end
            endcase
        end
    end

    // Data and carrier are launched on the receive clock, so one capture stage suffices.
    mst_pkg::mst_rx_state_t rx_state_reg;
    logic                   rxd_q_reg;
    logic                   crs_q_reg;
    logic [1:0]             crs_low_reg;
    logic                   carrier_end;
    logic                   prev_bit_reg;
    logic [7:0]             rx_shift_reg;
    logic [2:0]             rx_cnt_reg;

    assign carrier_end = !crs_q_reg && (crs_low_reg == 2'(mst_pkg::CRS_END_CYCLES - 1));

    always_ff @(posedge i_rx_bit_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            rxd_q_reg   <= 1'b0;
            crs_q_reg   <= 1'b0;
            crs_low_reg <= 2'h0;
        end else begin
            rxd_q_reg <= i_rx_data;
            crs_q_reg <= i_carrier_sense_in;
            if (crs_q_reg) begin
                crs_low_reg <= 2'h0;
            end else if (crs_low_reg != 2'h3) begin
                crs_low_reg <= crs_low_reg + 2'h1;
            end
        end
    end

    always_ff @(posedge i_rx_bit_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            rx_state_reg <= mst_pkg::RX_IDLE;
            prev_bit_reg <= 1'b0;
            rx_shift_reg <= mst_pkg::BYTE_RESET;
            rx_cnt_reg   <= 3'h0;
            rx_info_reg  <= '{align_error: 1'b0, data: mst_pkg::BYTE_RESET};
            rxb_tgl_reg  <= 1'b0;
            rxe_tgl_reg  <= 1'b0;
        end else begin
            case (rx_state_reg)
                mst_pkg::RX_IDLE: begin
                    prev_bit_reg <= 1'b0;
                    if (crs_q_reg) begin
                        rx_state_reg <= mst_pkg::RX_HUNT;
                    end
                end
                mst_pkg::RX_HUNT: begin
                    if (carrier_end) begin
                        rx_state_reg <= mst_pkg::RX_IDLE;
                    end else if (crs_q_reg) begin
                        prev_bit_reg <= rxd_q_reg;
                        if (prev_bit_reg && rxd_q_reg) begin
                            rx_cnt_reg   <= 3'h0;
                            rx_state_reg <= mst_pkg::RX_DATA;
                        end
                    end
                end
                mst_pkg::RX_DATA: begin
                    if (carrier_end) begin
                        rx_info_reg.align_error <= (rx_cnt_reg > 3'(mst_pkg::DRIBBLE_LIMIT));
                        rx_state_reg            <= mst_pkg::RX_END;
                    end else if (crs_q_reg) begin
                        rx_shift_reg <= {rxd_q_reg, rx_shift_reg[7:1]};
                        rx_cnt_reg   <= rx_cnt_reg + 3'h1;
                        if (rx_cnt_reg == 3'h7) begin
                            rx_info_reg <= '{align_error: 1'b0, data: {rxd_q_reg, rx_shift_reg[7:1]}};
                            rxb_tgl_reg <= ~rxb_tgl_reg;
                        end
                    end
                end
                mst_pkg::RX_END: begin
                    rxe_tgl_reg  <= ~rxe_tgl_reg;
                    rx_state_reg <= mst_pkg::RX_IDLE;
                end
                default: begin
                    rx_state_reg <= mst_pkg::RX_IDLE;
                end
            endcase
        end
    end

endmodule : mst_serial_side

// File: verification/mst_properties.sv
module mst_properties (
    // Clocks and reset.
    input wire logic                    i_core_clk,
    input wire logic                    i_tx_bit_clock,
    input wire logic                    i_rx_bit_clock,
    input wire logic                    i_resetn,
    // Core side.
    input wire logic                    i_core_clk_en,
    input wire logic                    i_tx_valid,
    input wire logic                    o_tx_ready,
    input wire logic                    o_tx_done,
    input wire mst_pkg::mst_tx_status_t o_transmit_status_reg,
    input wire logic                    o_rx_byte_valid,
    input wire logic                    o_rx_frame_end,
    // Link side.
    input wire logic                    i_collision,
    input wire logic                    o_tx_line_enable,
    input wire logic                    o_tx_data,
    input wire logic                    i_carrier_sense_in
);
    logic [5:0] ones_reg;
    logic [6:0] idle_reg;
    logic       heard_reg;
    logic       col_reg;
    logic [1:0] low_reg;

    always_ff @(posedge i_tx_bit_clock or negedge i_resetn) begin
        if (!i_resetn)
            ones_reg <= 6'h00;
        else if (!(o_tx_line_enable && o_tx_data))
            ones_reg <= 6'h00;
        else if (ones_reg != 6'h3f)
            ones_reg <= ones_reg + 6'h01;
    end

    always_ff @(posedge i_tx_bit_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            idle_reg  <= 7'h00;
            heard_reg <= 1'b0;
        end else if (o_tx_line_enable) begin
            idle_reg  <= 7'h00;
            heard_reg <= 1'b0;
        end else if (idle_reg != 7'h40) begin
            idle_reg  <= idle_reg + 7'h01;
            heard_reg <= heard_reg | i_collision;
        end
    end

    always_ff @(posedge i_tx_bit_clock or negedge i_resetn) begin
        if (!i_resetn)
            col_reg <= 1'b0;
        else
            col_reg <= o_tx_line_enable && (col_reg || i_collision);
    end

    always_ff @(posedge i_rx_bit_clock or negedge i_resetn) begin
        if (!i_resetn)
            low_reg <= 2'h0;
        else if (i_carrier_sense_in)
            low_reg <= 2'h0;
        else if (low_reg != 2'h3)
            low_reg <= low_reg + 2'h1;
    end

    a_first_bit_one: assert property (@(posedge i_tx_bit_clock) disable iff (!i_resetn)
        $rose(o_tx_line_enable) |-> o_tx_data ##1 !o_tx_data) else $error("frame did not open with 1 then 0");
    a_jam_window: assert property (@(posedge i_tx_bit_clock) disable iff (!i_resetn)
        $rose(i_collision) && o_tx_line_enable && !col_reg |-> o_tx_line_enable [*8] ##[25:37] !o_tx_line_enable)
        else $error("jam did not end in its window");
    a_jam_ones: assert property (@(posedge i_tx_bit_clock) disable iff (!i_resetn)
        $fell(o_tx_line_enable) && col_reg |-> ones_reg >= 6'h20) else $error("jam shorter than 32 ones");
    a_heartbeat_flag: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        o_tx_done && !o_transmit_status_reg.collided && !o_transmit_status_reg.underrun
        |-> idle_reg >= 7'h3e && o_transmit_status_reg.heartbeat_missing_flag == !heard_reg)
        else $error("heartbeat flag wrong");
    a_end_two_low: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        o_rx_frame_end |-> low_reg >= 2'h2) else $error("frame end before two low clocks");
    a_byte_pulse: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        o_rx_byte_valid |=> !o_rx_byte_valid) else $error("byte strobe too long");
    a_done_pulse: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        o_tx_done |=> !o_tx_done) else $error("done strobe too long");
    a_ready_drop: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        i_core_clk_en && i_tx_valid && o_tx_ready |=> !o_tx_ready) else $error("ready held after take");
    a_status_moves: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
        !$stable(o_transmit_status_reg) |-> o_tx_done) else $error("status changed without done");
endmodule : mst_properties

bind mst_serial_side mst_properties u_props (
    .i_core_clk, .i_tx_bit_clock, .i_rx_bit_clock, .i_resetn, .i_core_clk_en, .i_tx_valid,
    .o_tx_ready, .o_tx_done, .o_transmit_status_reg, .o_rx_byte_valid, .o_rx_frame_end,
    .i_collision, .o_tx_line_enable, .o_tx_data, .i_carrier_sense_in
);

// File: verification/mst_link_model.sv
module mst_link_model (
    // Base clock and transmit line.
    input  wire logic i_lnk_clk,
    input  wire logic i_tx_line_enable,
    // Towards the device.
    output logic      o_tx_bit_clock,
    output logic      o_rx_bit_clock,
    output logic      o_collision,
    output logic      o_carrier_sense_in,
    output logic      o_rx_data
);
    timeunit 1ns;
    timeprecision 1ps;
    int         hb_on  = 1;
    int         col_at = 0;
    int         bit_n  = 0;
    int         idle_n = 0;
    logic       run    = 1'b0;
    logic [1:0] div    = 2'h0;
    logic [7:0] rxq[$];

    initial begin
        o_tx_bit_clock     = 1'b0;
        o_rx_bit_clock     = 1'b0;
        o_collision        = 1'b0;
        o_carrier_sense_in = 1'b0;
        o_rx_data          = 1'b0;
    end

    // Bit clocks at an eighth of the base rate; receive clock stops outside frames.
    always @(posedge i_lnk_clk) begin
        div <= div + 2'h1;
        if (div == 2'h0)
            o_tx_bit_clock <= ~o_tx_bit_clock;
        if (div == 2'h2)
            o_rx_bit_clock <= run & ~o_rx_bit_clock;
    end

    // Collision from the commanded bit until enable drops; heartbeat two clocks.
    always @(posedge o_tx_bit_clock) begin
        #1;
        if (i_tx_line_enable) begin
            bit_n  = bit_n + 1;
            idle_n = 0;
            if (bit_n == col_at)
                o_collision = 1'b1;
        end else begin
            bit_n       = 0;
            idle_n      = idle_n + 1;
            o_collision = hb_on != 0 && (idle_n == 8 || idle_n == 9);
        end
    end

    task automatic put_bit(input logic b, input logic carrier_sense_in);
        @(posedge o_rx_bit_clock);
        #1;
        o_rx_data          = b;
        o_carrier_sense_in = carrier_sense_in;
    endtask : put_bit

    task automatic send_rx(input int pre, input int drib);
        int         i;
        logic [7:0] b;
        run = 1'b1;
        for (i = 0; i < pre; i++) put_bit(~i[0], 1'b1);
        put_bit(1'b1, 1'b1);
        put_bit(1'b1, 1'b1);
        while (rxq.size() > 0) begin
            b = rxq.pop_front();
            for (i = 0; i < 8; i++) put_bit(b[i], 1'b1);
        end
        for (i = 0; i < drib; i++) put_bit(1'($urandom), 1'b1);
        for (i = 0; i < 40; i++) put_bit(~o_rx_data, 1'b0);
        run = 1'b0;
    endtask : send_rx
endmodule : mst_link_model

// File: verification/mst_serial_side_bench.sv
module mst_serial_side_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic                    clk      = 1'b0;
    logic                    lnk      = 1'b0;
    logic                    resetn   = 1'b0;
    logic                    tx_valid = 1'b0;
    mst_pkg::mst_tx_byte_t   tx_byte  = '0;
    logic                    tx_ready, tx_done, rxv, rxe, txe, txd, tx_bit_clock, rx_bit_clock, col, carrier_sense_in, rxd;
    mst_pkg::mst_tx_status_t st;
    mst_pkg::mst_rx_info_t   rxi;
    int                      err_count   = 0;
    int                      checks_done = 0;
    int                      frames      = 0;
    int                      dribs[5]    = '{0, 3, 5, 6, 7};
    logic                    exp_align   = 1'b0;
    logic                    txbits[$];
    logic [7:0]              rxexp[$];

    mst_serial_side u_dut (
        .i_core_clk(clk), .i_core_clk_en(1'b1), .i_resetn(resetn), .i_tx_valid(tx_valid), .i_tx_byte(tx_byte),
        .o_tx_ready(tx_ready), .o_tx_done(tx_done), .o_transmit_status_reg(st), .o_rx_info(rxi),
        .o_rx_byte_valid(rxv), .o_rx_frame_end(rxe), .i_tx_bit_clock(tx_bit_clock), .i_collision(col),
        .o_tx_line_enable(txe), .o_tx_data(txd), .i_rx_bit_clock(rx_bit_clock), .i_carrier_sense_in(carrier_sense_in), .i_rx_data(rxd));
    mst_link_model u_link (.i_lnk_clk(lnk), .i_tx_line_enable(txe), .o_tx_bit_clock(tx_bit_clock), .o_rx_bit_clock(rx_bit_clock),
        .o_collision(col), .o_carrier_sense_in(carrier_sense_in), .o_rx_data(rxd));

    always #12.5 clk = ~clk;
    initial begin
        #3.7;
        forever #6 lnk = ~lnk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD at %0t: saw %0h, expected %0h", $time, seen, exp);
        end
    endtask : check

    task automatic conclude();
        $display("checks %0d, mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : conclude

    always @(negedge tx_bit_clock) if (txe === 1'b1) txbits.push_back(txd);
    always @(negedge clk) begin
        if (rxv === 1'b1) check(rxi.data, rxexp.size() > 0 ? rxexp.pop_front() : 32'h100);
        if (rxe === 1'b1) begin
            check(rxi.align_error, exp_align);
            check(rxexp.size(), 0);
            frames++;
        end
    end

    task automatic put_byte(input logic [7:0] v, input logic last);
        int t;
        @(negedge clk);
        tx_valid = 1'b1;
        tx_byte  = '{last: last, data: v};
        for (t = 0; t < 400 && tx_ready !== 1'b1; t++) @(negedge clk);
        check(t < 400, 1);
        @(negedge clk);
        tx_valid = 1'b0;
    endtask : put_byte

    task automatic tx_frame(input int n, input int col_at, input int hb);
        logic [7:0] d[$];
        logic       e[$];
        int         k;
        txbits = {};
        u_link.col_at = col_at;
        u_link.hb_on  = hb;
        for (k = 0; k < 64; k++) e.push_back(k > 61 || k % 2 == 0);
        for (k = 0; k < n; k++) begin
            d.push_back(col_at > 0 ? 8'h00 : 8'($urandom));
            put_byte(d[k], k == n - 1);
        end
        if (col_at > 0)
            for (k = 0; k < 48; k++) e.push_back(k > 15);
        else
            foreach (d[j]) for (k = 0; k < 8; k++) e.push_back(d[j][k]);
        for (k = 0; k < 4000 && tx_done !== 1'b1; k++) @(negedge clk);
        check(k < 4000, 1);
        check(txbits.size(), e.size());
        foreach (e[j]) check(txbits[j], e[j]);
        check(st.collided, col_at > 0);
        if (col_at == 0) check(st.heartbeat_missing_flag, hb == 0);
        $display("tx frame of %0d bytes done", n);
    endtask : tx_frame

    task automatic rx_frame(input int drib);
        int         n;
        int         k;
        logic [7:0] b;
        n = 1 + $urandom % 4;
        exp_align = drib > 5;
        for (k = 0; k < n; k++) begin
            b = 8'($urandom);
            rxexp.push_back(b);
            u_link.rxq.push_back(b);
        end
        u_link.send_rx(8 + 2 * ($urandom % 6), drib);
        $display("rx frame with %0d dribble bits done", drib);
    endtask : rx_frame

    initial begin
        void'($urandom(16));
        repeat (32) @(negedge clk);
        resetn = 1'b1;
        repeat (8) @(negedge clk);
        check(tx_ready, 1);
        check(txe, 0);
        tx_frame(3, 0, 1);
        tx_frame(1, 0, 0);
        tx_frame(4, 74, 1);
        foreach (dribs[i]) rx_frame(dribs[i]);
        repeat (100) @(negedge clk);
        check(frames, 5);
        conclude();
    end

    initial begin
        #1000000;
        err_count++;
        conclude();
    end
endmodule : mst_serial_side_bench
